/* design/bti_branch_unit.sv */
// Purpose: Decodes control transfer operations, resolves the branch and
//   times each instruction in mclk cycles.
// Assumes: Operand values are stable on the issue cycle; one clock domain.
// Notes: Issue is ignored while an instruction is still running.
`include "bti_cfg.svh"

// What this block does
// - One instruction cycle equals one mclk.
// - Short relative jump: two bytes, three cycles.
// - Carry and accumulator branches: two bytes, three cycles.
// - Register decrement branch: two bytes, three cycles.
// - Long jump and call: three bytes, four cycles.
// - Interrupt-issued long call takes three cycles.
// - Direct bit branches: three bytes, four cycles.
// - Bit set-and-clear branch also clears the bit.
// - Accumulator compare branches: three bytes, four cycles.
// - Register or indirect compare: three bytes, four.
// - Direct byte decrement branch: three bytes, four.
// - External data move takes four cycles unwaited.
// - Each wait state adds one cycle.
// - Wait count limited to zero to seven; larger counts saturate at seven.
module bti_branch_unit (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Instruction issue.
	input wire logic issue,
	input wire logic [7:0] op_code,
	input wire logic [15:0] instr_addr,
	input wire logic [7:0] op_byte1,
	input wire logic [7:0] op_byte2,
	input wire logic from_interrupt,
	// Core state.
	input wire logic carry_flag,
	input wire logic [7:0] acc_value,
	input wire logic [7:0] operand_value,
	input wire logic [7:0] external_wait_count,
	// Results.
	output logic busy,
	output logic done,
	output logic illegal_op,
	output logic branch_taken,
	output logic [15:0] branch_target,
	output logic [1:0] instr_length,
	output logic [3:0] instr_cycles,
	output logic write_back,
	output logic [7:0] write_value,
	output logic bit_clear
);

	bti_pkg::bti_op_t op;
	logic accept;
	logic [1:0] len_next;
	logic [3:0] cyc_next;
	logic taken_next;
	logic [15:0] target_next;
	logic [7:0] rel_byte;
	logic [15:0] follow_addr;
	logic [7:0] dec_value;
	logic [2:0] wait_states;
	logic wb_next;
	logic clr_next;
	logic branch_taken_reg;
	logic [15:0] branch_target_reg;
	logic [1:0] instr_length_reg;
	logic [3:0] instr_cycles_reg;
	logic write_back_reg;
	logic [7:0] write_value_reg;
	logic bit_clear_reg;
	logic illegal_reg;
	logic [3:0] left_reg;
	logic wb_pend_reg;
	logic clr_pend_reg;
	logic last_next;

	// Map the select code onto an operation.
	always_comb begin
		case (op_code)
			`BTI_CODE_SHORT_JUMP: op = bti_pkg::OP_SHORT_JUMP;
			`BTI_CODE_JUMP_CARRY: op = bti_pkg::OP_JUMP_CARRY;
			`BTI_CODE_JUMP_NO_CARRY: op = bti_pkg::OP_JUMP_NO_CARRY;
			`BTI_CODE_JUMP_ACC_ZERO: op = bti_pkg::OP_JUMP_ACC_ZERO;
			`BTI_CODE_JUMP_ACC_NONZERO: op = bti_pkg::OP_JUMP_ACC_NONZERO;
			`BTI_CODE_DEC_BRANCH_REG: op = bti_pkg::OP_DEC_BRANCH_REG;
			`BTI_CODE_LONG_JUMP: op = bti_pkg::OP_LONG_JUMP;
			`BTI_CODE_LONG_CALL: op = bti_pkg::OP_LONG_CALL;
			`BTI_CODE_JUMP_BIT_SET: op = bti_pkg::OP_JUMP_BIT_SET;
			`BTI_CODE_JUMP_BIT_CLEAR: op = bti_pkg::OP_JUMP_BIT_CLEAR;
			`BTI_CODE_JUMP_BIT_SET_CLEAR: op = bti_pkg::OP_JUMP_BIT_SET_CLEAR;
			`BTI_CODE_CMP_ACC_DIRECT: op = bti_pkg::OP_CMP_ACC_DIRECT;
			`BTI_CODE_CMP_ACC_IMM: op = bti_pkg::OP_CMP_ACC_IMM;
			`BTI_CODE_CMP_OPERAND_IMM: op = bti_pkg::OP_CMP_OPERAND_IMM;
			`BTI_CODE_DEC_BRANCH_DIRECT: op = bti_pkg::OP_DEC_BRANCH_DIRECT;
			`BTI_CODE_EXT_DATA_MOVE: op = bti_pkg::OP_EXT_DATA_MOVE;
			default: op = bti_pkg::OP_NONE;
		endcase
	end

	// Out-of-range wait counts saturate so a bad value cannot wrap short.
	assign wait_states = (external_wait_count > `BTI_WAIT_MAX) ?
		3'(`BTI_WAIT_MAX) : external_wait_count[2:0];

	assign dec_value = operand_value - 8'h01;
	assign accept = issue && !busy && (op != bti_pkg::OP_NONE);

	// Length, cycle count and outcome of each operation.
	always_comb begin
		len_next = `BTI_LEN_LONG;
		cyc_next = `BTI_CYC_LONG;
		taken_next = 1'b0;
		wb_next = 1'b0;
		clr_next = 1'b0;
		case (op)
			bti_pkg::OP_SHORT_JUMP: begin
				len_next = `BTI_LEN_SHORT;
				cyc_next = `BTI_CYC_SHORT;
				taken_next = 1'b1;
			end
			bti_pkg::OP_JUMP_CARRY, bti_pkg::OP_JUMP_NO_CARRY: begin
				len_next = `BTI_LEN_SHORT;
				cyc_next = `BTI_CYC_SHORT;
				taken_next = carry_flag ^ (op == bti_pkg::OP_JUMP_NO_CARRY);
			end
			bti_pkg::OP_JUMP_ACC_ZERO, bti_pkg::OP_JUMP_ACC_NONZERO: begin
				len_next = `BTI_LEN_SHORT;
				cyc_next = `BTI_CYC_SHORT;
				taken_next = (acc_value == 8'h00) ^
					(op == bti_pkg::OP_JUMP_ACC_NONZERO);
			end
			bti_pkg::OP_DEC_BRANCH_REG: begin
				len_next = `BTI_LEN_SHORT;
				cyc_next = `BTI_CYC_SHORT;
				taken_next = (dec_value != 8'h00);
				wb_next = 1'b1;
			end
			bti_pkg::OP_LONG_JUMP: begin
				taken_next = 1'b1;
			end
			bti_pkg::OP_LONG_CALL: begin
				taken_next = 1'b1;
				if (from_interrupt) begin
					cyc_next = `BTI_CYC_CALL_IRQ;
				end
			end
			bti_pkg::OP_JUMP_BIT_SET: begin
				taken_next = operand_value[0];
			end
			bti_pkg::OP_JUMP_BIT_CLEAR: begin
				taken_next = !operand_value[0];
			end
			bti_pkg::OP_JUMP_BIT_SET_CLEAR: begin
				taken_next = operand_value[0];
				clr_next = operand_value[0];
			end
			bti_pkg::OP_CMP_ACC_DIRECT: begin
				taken_next = (acc_value != operand_value);
			end
			bti_pkg::OP_CMP_ACC_IMM: begin
				taken_next = (acc_value != op_byte1);
			end
			bti_pkg::OP_CMP_OPERAND_IMM: begin
				taken_next = (operand_value != op_byte1);
			end
			bti_pkg::OP_DEC_BRANCH_DIRECT: begin
				taken_next = (dec_value != 8'h00);
				wb_next = 1'b1;
			end
			bti_pkg::OP_EXT_DATA_MOVE: begin
				len_next = `BTI_LEN_MOVE;
				cyc_next = `BTI_CYC_MOVE_BASE + {1'b0, wait_states};
			end
			default: len_next = `BTI_LEN_LONG;
		endcase
	end

	// Relative targets count from the byte after the whole instruction.
	assign follow_addr = instr_addr + {14'h0000, len_next};
	assign rel_byte = (len_next == `BTI_LEN_SHORT) ? op_byte1 : op_byte2;
	always_comb begin
		if (op == bti_pkg::OP_LONG_JUMP || op == bti_pkg::OP_LONG_CALL) begin
			target_next = {op_byte1, op_byte2};
		end else begin
			target_next = follow_addr + {{8{rel_byte[7]}}, rel_byte};
		end
	end

	// Instruction results are captured once, when the issue is accepted.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			branch_taken_reg <= 1'b0;
			branch_target_reg <= `BTI_RST_ADDR;
			instr_length_reg <= 2'h0;
			instr_cycles_reg <= `BTI_RST_CYC;
			write_value_reg <= `BTI_RST_BYTE;
			wb_pend_reg <= 1'b0;
			clr_pend_reg <= 1'b0;
		end else if (accept) begin
			branch_taken_reg <= taken_next;
			branch_target_reg <= target_next;
			instr_length_reg <= len_next;
			instr_cycles_reg <= cyc_next;
			write_value_reg <= dec_value;
			wb_pend_reg <= wb_next;
			clr_pend_reg <= clr_next;
		end
	end

	// A private countdown mirrors the timer, since its count is not exported.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			left_reg <= `BTI_RST_CYC;
		end else if (accept) begin
			left_reg <= cyc_next;
		end else if (busy) begin
			left_reg <= left_reg - 4'h1;
		end
	end

	// The next cycle is the last busy one, the cycle in which done stands.
	assign last_next = busy && (left_reg == 4'h2);

	// Side effects pulse in the last cycle, so the core commits them once.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			write_back_reg <= 1'b0;
			bit_clear_reg <= 1'b0;
		end else begin
			write_back_reg <= wb_pend_reg && last_next;
			bit_clear_reg <= clr_pend_reg && last_next;
		end
	end

	// Unknown codes are flagged for one cycle and start nothing.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			illegal_reg <= 1'b0;
		end else begin
			illegal_reg <= issue && !busy && (op == bti_pkg::OP_NONE);
		end
	end

	// Occupancy timer: busy for exactly the instruction's cycle count.
	bti_cycle_timer u_timer (
		.mclk(mclk),
		.reset(reset),
		.load(accept),
		.count(cyc_next),
		.busy(busy),
		.done(done)
	);

	assign branch_taken = branch_taken_reg;
	assign branch_target = branch_target_reg;
	assign instr_length = instr_length_reg;
	assign instr_cycles = instr_cycles_reg;
	// Pulses aligned with done are registered from the private countdown and a held flop.
	assign write_back = write_back_reg;
	assign bit_clear = bit_clear_reg;
	assign write_value = write_value_reg;
	assign illegal_op = illegal_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_run3;
		busy [*3] ##1 !busy;
	endsequence
	sequence s_run4;
		busy [*4] ##1 !busy;
	endsequence

	chk_short_jump_time: assert property (
		accept && op == bti_pkg::OP_SHORT_JUMP |=> s_run3)
		else $error("short jump did not take three cycles");
	chk_cond_branch_time: assert property (
		accept && (op == bti_pkg::OP_JUMP_CARRY ||
		op == bti_pkg::OP_JUMP_ACC_ZERO) |=> s_run3)
		else $error("conditional branch did not take three cycles");
	chk_reg_dec_time: assert property (
		accept && op == bti_pkg::OP_DEC_BRANCH_REG
		|=> s_run3 and instr_length == 2'h2)
		else $error("register decrement branch timing wrong");
	chk_long_call_time: assert property (
		accept && op == bti_pkg::OP_LONG_CALL && !from_interrupt
		|=> s_run4)
		else $error("program long call did not take four cycles");
	chk_irq_call_time: assert property (
		accept && op == bti_pkg::OP_LONG_CALL && from_interrupt
		|=> s_run3)
		else $error("interrupt long call did not take three cycles");
	chk_bit_branch_time: assert property (
		accept && op == bti_pkg::OP_JUMP_BIT_CLEAR
		|=> branch_taken == !$past(operand_value[0]) ##0 s_run4)
		else $error("bit branch outcome or timing wrong");
	chk_bit_clear_end: assert property (
		accept && op == bti_pkg::OP_JUMP_BIT_SET_CLEAR && operand_value[0]
		|=> !bit_clear [*3] ##1 (bit_clear && done))
		else $error("bit clear not pulsed in last cycle");
	chk_compare_branch: assert property (
		accept && op == bti_pkg::OP_CMP_ACC_IMM
		|=> branch_taken == ($past(acc_value) != $past(op_byte1)))
		else $error("compare branch outcome wrong");
	chk_operand_compare: assert property (
		accept && op == bti_pkg::OP_CMP_OPERAND_IMM |=> s_run4)
		else $error("operand compare did not take four cycles");
	chk_direct_dec: assert property (
		accept && op == bti_pkg::OP_DEC_BRANCH_DIRECT
		|=> write_value == $past(operand_value) - 8'h01 ##3 write_back)
		else $error("direct decrement write back wrong");
	chk_move_waits: assert property (
		accept && op == bti_pkg::OP_EXT_DATA_MOVE
		|=> instr_cycles == 4'h4 + {1'b0, $past(wait_states)})
		else $error("external move cycle count wrong");
	chk_move_plain: assert property (
		accept && op == bti_pkg::OP_EXT_DATA_MOVE &&
		external_wait_count == 8'h00 |=> s_run4)
		else $error("unwaited external move not four cycles");
	chk_wait_clamp: assert property (
		accept && op == bti_pkg::OP_EXT_DATA_MOVE &&
		external_wait_count > 8'h07 |=> instr_cycles == 4'hB)
		else $error("wait count not limited to seven");
	chk_rel_target: assert property (
		accept && op == bti_pkg::OP_SHORT_JUMP |=> branch_target ==
		$past(instr_addr) + 16'h0002 + {{8{$past(op_byte1[7])}},
		$past(op_byte1)})
		else $error("relative target wrong");

endmodule // bti_branch_unit

/* design/bti_cfg.svh */
// Purpose: Constants for the branch instruction timing block.
// Assumes: Included by bare name from the design files and the bench.
// Notes: Operation select codes come from the upstream opcode decoder.
`ifndef BTI_CFG_SVH
`define BTI_CFG_SVH

// Operation select codes presented on op_code.
`define BTI_CODE_SHORT_JUMP 8'h01
`define BTI_CODE_JUMP_CARRY 8'h02
`define BTI_CODE_JUMP_NO_CARRY 8'h03
`define BTI_CODE_JUMP_ACC_ZERO 8'h04
`define BTI_CODE_JUMP_ACC_NONZERO 8'h05
`define BTI_CODE_DEC_BRANCH_REG 8'h06
`define BTI_CODE_LONG_JUMP 8'h07
`define BTI_CODE_LONG_CALL 8'h08
`define BTI_CODE_JUMP_BIT_SET 8'h09
`define BTI_CODE_JUMP_BIT_CLEAR 8'h0A
`define BTI_CODE_JUMP_BIT_SET_CLEAR 8'h0B
`define BTI_CODE_CMP_ACC_DIRECT 8'h0C
`define BTI_CODE_CMP_ACC_IMM 8'h0D
`define BTI_CODE_CMP_OPERAND_IMM 8'h0E
`define BTI_CODE_DEC_BRANCH_DIRECT 8'h0F
`define BTI_CODE_EXT_DATA_MOVE 8'h10

// Instruction lengths in bytes.
`define BTI_LEN_SHORT 2'h2
`define BTI_LEN_LONG 2'h3
`define BTI_LEN_MOVE 2'h1

// Cycle counts; one cycle is one mclk period.
`define BTI_CYC_SHORT 4'h3
`define BTI_CYC_LONG 4'h4
`define BTI_CYC_CALL_IRQ 4'h3
`define BTI_CYC_MOVE_BASE 4'h4

// Largest accepted external wait count and the field width.
`define BTI_WAIT_MAX 8'h07
`define BTI_WAIT_W 3

// Reset values.
`define BTI_RST_ADDR 16'h0000
`define BTI_RST_BYTE 8'h00
`define BTI_RST_CYC 4'h0

`endif

/* design/bti_pkg.sv */
// Purpose: Types shared by the branch instruction timing design.
// Assumes: Nothing beyond the constants header.
// Notes: Encodings are left to the tools.
package bti_pkg;

	// Control transfer operations recognised by the block.
	typedef enum logic [4:0] {
		OP_NONE,
		OP_SHORT_JUMP,
		OP_JUMP_CARRY,
		OP_JUMP_NO_CARRY,
		OP_JUMP_ACC_ZERO,
		OP_JUMP_ACC_NONZERO,
		OP_DEC_BRANCH_REG,
		OP_LONG_JUMP,
		OP_LONG_CALL,
		OP_JUMP_BIT_SET,
		OP_JUMP_BIT_CLEAR,
		OP_JUMP_BIT_SET_CLEAR,
		OP_CMP_ACC_DIRECT,
		OP_CMP_ACC_IMM,
		OP_CMP_OPERAND_IMM,
		OP_DEC_BRANCH_DIRECT,
		OP_EXT_DATA_MOVE
	} bti_op_t;

endpackage

/* design/bti_cycle_timer.sv */
// Purpose: Holds busy for a loaded number of mclk cycles.
// Assumes: A loaded count is at least two.
// Notes: done marks the last busy cycle.
`include "bti_cfg.svh"

module bti_cycle_timer (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Load request.
	input wire logic load,
	input wire logic [3:0] count,
	// Status.
	output logic busy,
	output logic done
);

	logic [3:0] remain_reg;
	logic busy_reg;
	logic done_reg;

	// Count down; done is set one cycle ahead so it comes from a flop.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			remain_reg <= `BTI_RST_CYC;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (load && !busy_reg) begin
			remain_reg <= count;
			busy_reg <= 1'b1;
			done_reg <= (count == 4'h1);
		end else if (busy_reg) begin
			remain_reg <= remain_reg - 4'h1;
			busy_reg <= (remain_reg != 4'h1);
			done_reg <= (remain_reg == 4'h2);
		end else begin
			done_reg <= 1'b0;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;

endmodule // bti_cycle_timer

/* verif/bti_branch_unit_tb.sv */
// Purpose: Self-checking bench for the branch instruction timing block.
// Assumes: Inputs change a fixed delay after the rising mclk edge.
// Notes: Table rows run back to back; reset and refusals are hand-written.
`include "bti_cfg.svh"

module bti_branch_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		logic [7:0] code;
		logic [15:0] addr;
		logic [7:0] b1, b2;
		logic cy;
		logic [7:0] acc, opnd, wt;
		logic irq, tk;
		logic [3:0] cyc;
	} bti_row_t;

	localparam int DLY = 5;
	logic mclk = 1'b0, reset = 1'b1, issue = 1'b0, from_interrupt = 1'b0;
	logic carry_flag = 1'b0;
	logic [7:0] op_code = 8'h00, op_byte1 = 8'h00, op_byte2 = 8'h00;
	logic [7:0] acc_value = 8'h00, operand_value = 8'h00;
	logic [7:0] external_wait_count = 8'h00;
	logic [15:0] instr_addr = 16'h0000;
	logic busy, done, illegal_op, branch_taken, write_back, bit_clear;
	logic [15:0] branch_target;
	logic [1:0] instr_length;
	logic [3:0] instr_cycles;
	logic [7:0] write_value;
	int errors = 0, n_compared = 0;
	bti_row_t rows [26];

	// Free-running core clock at 20 MHz.
	always #25 mclk = ~mclk;

	bti_branch_unit u_dut (.mclk(mclk), .reset(reset), .issue(issue),
		.op_code(op_code), .instr_addr(instr_addr), .op_byte1(op_byte1),
		.op_byte2(op_byte2), .from_interrupt(from_interrupt),
		.carry_flag(carry_flag), .acc_value(acc_value),
		.operand_value(operand_value),
		.external_wait_count(external_wait_count), .busy(busy), .done(done),
		.illegal_op(illegal_op), .branch_taken(branch_taken),
		.branch_target(branch_target), .instr_length(instr_length),
		.instr_cycles(instr_cycles), .write_back(write_back),
		.write_value(write_value), .bit_clear(bit_clear));

	// Every comparison goes through here so that counting stays in one place.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen,
				exp);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [1:0] len(input logic [7:0] c);
		if (c == 8'h10)
			return 2'h1;
		return (c <= 8'h06) ? 2'h2 : 2'h3;
	endfunction

	// Relative offset sits in the last byte of the instruction.
	function automatic logic [15:0] tgt(input bti_row_t r);
		logic [7:0] off;
		off = (len(r.code) == 2'h2) ? r.b1 : r.b2;
		if (r.code == 8'h07 || r.code == 8'h08)
			return {r.b1, r.b2};
		return r.addr + {14'h0000, len(r.code)} + {{8{off[7]}}, off};
	endfunction

	// Issues one instruction and follows it to the end; poke retries issue
	// while busy, which must leave the running instruction untouched.
	task automatic run_op(input bti_row_t r, input bit poke);
		int k;
		logic dec;
		dec = (r.code == 8'h06) || (r.code == 8'h0F);
		op_code = r.code;
		instr_addr = r.addr;
		op_byte1 = r.b1;
		op_byte2 = r.b2;
		carry_flag = r.cy;
		acc_value = r.acc;
		operand_value = r.opnd;
		external_wait_count = r.wt;
		from_interrupt = r.irq;
		issue = 1'b1;
		@(posedge mclk);
		#DLY;
		// A poke holds issue up for one more edge with another code on it.
		issue = poke;
		if (poke)
			op_code = 8'h01;
		check(busy, 16'h1);
		k = 1;
		while (done !== 1'b1 && k < 16) begin
			@(posedge mclk);
			#DLY;
			issue = 1'b0;
			k++;
		end
		check(k[15:0], {12'h000, r.cyc});
		check(instr_cycles, {12'h000, r.cyc});
		check(branch_taken, r.tk);
		check(instr_length, len(r.code));
		if (r.code != 8'h10)
			check(branch_target, tgt(r));
		check(write_back, dec);
		if (dec)
			check(write_value, 8'(r.opnd - 8'h01));
		check(bit_clear, r.code == 8'h0B && r.opnd[0]);
		@(posedge mclk);
		#DLY;
		check(busy, 16'h0);
		check(done, 16'h0);
	endtask

	// Watchdog sized well beyond the fewer than two hundred cycles the run needs.
	initial begin
		#100000;
		errors++;
		finish_test();
	end

	initial begin
		rows = '{
		'{8'h01,16'h0100,8'hFE,8'h00,0,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h01,16'hFFFE,8'h7F,8'h00,0,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h02,16'h0200,8'h10,8'h00,1,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h02,16'h0200,8'h10,8'h00,0,8'h00,8'h00,8'h00,0,0,4'h3},
		'{8'h03,16'h0200,8'h80,8'h00,0,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h03,16'h0200,8'h10,8'h00,1,8'h00,8'h00,8'h00,0,0,4'h3},
		'{8'h04,16'h0200,8'h10,8'h00,0,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h04,16'h0200,8'h10,8'h00,0,8'h01,8'h00,8'h00,0,0,4'h3},
		'{8'h05,16'h0200,8'h10,8'h00,0,8'h80,8'h00,8'h00,0,1,4'h3},
		'{8'h06,16'h0200,8'hF0,8'h00,0,8'h00,8'h01,8'h00,0,0,4'h3},
		'{8'h06,16'h0200,8'hF0,8'h00,0,8'h00,8'h00,8'h00,0,1,4'h3},
		'{8'h07,16'h0200,8'h12,8'h34,0,8'h00,8'h00,8'h00,0,1,4'h4},
		'{8'h08,16'h0200,8'hAB,8'hCD,0,8'h00,8'h00,8'h00,0,1,4'h4},
		'{8'h08,16'h0200,8'hAB,8'hCD,0,8'h00,8'h00,8'h00,1,1,4'h3},
		'{8'h09,16'h0200,8'h20,8'h80,0,8'h00,8'h01,8'h00,0,1,4'h4},
		'{8'h0A,16'h0200,8'h20,8'h10,0,8'h00,8'h00,8'h00,0,1,4'h4},
		'{8'h0A,16'h0200,8'h20,8'h10,0,8'h00,8'h01,8'h00,0,0,4'h4},
		'{8'h0B,16'h0200,8'h20,8'h10,0,8'h00,8'h01,8'h00,0,1,4'h4},
		'{8'h0B,16'h0200,8'h20,8'h10,0,8'h00,8'hFE,8'h00,0,0,4'h4},
		'{8'h0C,16'h0200,8'h30,8'h10,0,8'h55,8'h55,8'h00,0,0,4'h4},
		'{8'h0D,16'h0200,8'h06,8'h80,0,8'h05,8'h00,8'h00,0,1,4'h4},
		'{8'h0E,16'h0200,8'h07,8'h10,0,8'h00,8'h07,8'h00,0,0,4'h4},
		'{8'h0F,16'h0200,8'h30,8'h10,0,8'h00,8'h02,8'h00,0,1,4'h4},
		'{8'h10,16'h0200,8'h00,8'h00,0,8'h00,8'h00,8'h00,0,0,4'h4},
		'{8'h10,16'h0200,8'h00,8'h00,0,8'h00,8'h00,8'h07,0,0,4'hB},
		'{8'h10,16'h0200,8'h00,8'h00,0,8'h00,8'h00,8'h09,0,0,4'hB}};
		repeat (12) @(posedge mclk);
		#DLY;
		reset = 1'b0;
		check({busy, done, illegal_op, branch_taken, write_back, bit_clear},
			16'h0);
		check(branch_target, 16'h0);
		check({instr_length, instr_cycles, write_value}, 16'h0);
		$display("reset test done");
		// Rows follow each other with one idle cycle between instructions.
		foreach (rows[i]) begin
			run_op(rows[i], i == 11);
			$display("row %0d done", i);
		end
		// Unknown codes are refused with a single pulse.
		for (int c = 0; c < 2; c++) begin
			op_code = (c == 0) ? 8'h00 : 8'h11;
			issue = 1'b1;
			@(posedge mclk);
			#DLY;
			issue = 1'b0;
			check(illegal_op, 16'h1);
			check(busy, 16'h0);
			@(posedge mclk);
			#DLY;
			check(illegal_op, 16'h0);
		end
		$display("illegal code test done");
		// A reset in mid-instruction must stop it at once.
		op_code = 8'h07;
		issue = 1'b1;
		@(posedge mclk);
		#DLY;
		issue = 1'b0;
		reset = 1'b1;
		#1;
		check(busy, 16'h0);
		check(branch_target, 16'h0);
		@(posedge mclk);
		#DLY;
		reset = 1'b0;
		@(posedge mclk);
		#DLY;
		check({busy, done}, 16'h0);
		run_op(rows[12], 1'b0);
		$display("mid-run reset test done");
		finish_test();
	end
endmodule // bti_branch_unit_tb
